// >>> bus_timing_defs.svh
// Register addresses, field positions, reset values and cycle counts
`ifndef BUS_TIMING_DEFS_SVH
`define BUS_TIMING_DEFS_SVH

// Register addresses on the core bus
`define A_BUS_UNIT_CFG        24'hFF_F900
`define A_IO_ZONE_TIMING_CFG       24'hFF_F902
`define A_FLCFG       24'hFF_F904
`define A_Z1CFG       24'hFF_F906
`define A_Z2CFG       24'hFF_F908

// Reset values and masks
`define RST_ZONE_CFG  16'h069F
`define RST_EWR       1'h1
`define CFG_RW_MASK   16'h0EFF
`define BUS_UNIT_CFG_FIXED    2'h3

// Zone configuration fields
`define F_WAIT        2:0
`define F_HOLD        4:3
`define B_RBE         5
`define B_WBR         6
`define B_BW          7
`define B_POST        9
`define B_PRE         10
`define B_FRE         11
`define B_EWR         0

// Address ranges
`define FL_PRG_LO     24'h00_0000
`define FL_PRG_HI     24'h03_FFFF
`define FL_DAT_LO     24'h0E_0000
`define FL_DAT_HI     24'h0E_1FFF
`define RAM0_LO       24'h0E_8000
`define RAM0_HI       24'h0E_91FF
`define RAM1_LO       24'h0E_C000
`define RAM1_HI       24'h0E_EBFF
`define PER0_LO       24'h0E_F000
`define PER0_HI       24'h0E_F1FF
`define PER1_LO       24'hFF_0000
`define PER1_HI       24'hFF_FBFF
`define IO_LO         24'hFF_FB00
`define IO_HI         24'hFF_FBFF

// Cycle counts
`define FAST_CYC      4'h1
`define NORM_CYC      4'h2
`define EARLY_CYC     4'h3
`define FL_RD_EXTRA   4'h1
`define FL_LATE_EXTRA 4'h1
`define FL_EARLY_EXTRA 4'h2
`define FL_FAST_WR    4'h1
`define PER_WAIT      4'h1
`define ACK_LAG       6'h01

`endif

// >>> bus_timing_pkg.sv
// Types shared by the bus timing design
package bus_timing_pkg;

  typedef enum logic [2:0] {Z_NONE, Z_FLASH, Z_RAM, Z_PERIPH, Z_IO, Z_EXT1, Z_EXT2} zone_t;
  typedef enum logic [1:0] {PH_IDLE, PH_GAP, PH_ACC, PH_HOLD} phase_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        write;
    logic        word;
    logic [15:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic [3:0] acc;
    logic [1:0] hold;
    logic       pre;
    logic       post;
    logic       split;
    logic       burst;
    logic       bwait;
  } timing_t;

  typedef struct packed {
    logic zone1_select_out;
    logic zone2_select_out;
    logic rd;
    logic wr;
  } ext_ctl_t;

  typedef struct packed {
    phase_t      ph;
    logic [3:0]  cnt;
    zone_t       zone;
    zone_t       last;
    logic        last_post;
    logic        half;
    core_req_t   req;
    timing_t     tm;
    logic [15:0] cfg_io;
    logic [15:0] cfg_fl;
    logic [15:0] cfg_z1;
    logic [15:0] cfg_z2;
    logic        early_write_select;
    logic        ack;
    logic        ready;
    logic [15:0] rdata;
    logic [23:0] mem_addr;
    ext_ctl_t    ext;
    logic [5:0]  run_len;
    logic        nogap;
  } state_t;

endpackage

// >>> zone_timing_calc.sv
// Per-access cycle counts derived from a zone configuration word
`timescale 1ns/1ps
`include "bus_timing_defs.svh"
module zone_timing_calc (
  input  wire bus_timing_pkg::zone_t   zone,
  input  wire logic [15:0]             cfg,
  input  wire logic                    write,
  input  wire logic                    word,
  input  wire logic                    early_write_select,
  output bus_timing_pkg::timing_t      tm
);
  import bus_timing_pkg::*;

  logic       fast_read_enable;
  logic [3:0] wt;

  // Fast read overrides wait and hold; the I/O zone has no fast read bit
  always_comb begin
    fast_read_enable      = cfg[`B_FRE] && (zone != Z_IO);
    wt       = fast_read_enable ? 4'h0 : {1'b0, cfg[`F_WAIT]};
    tm       = '0;
    tm.hold  = fast_read_enable ? 2'h0 : cfg[`F_HOLD];
    tm.pre   = cfg[`B_PRE] && (zone != Z_IO);
    tm.post  = cfg[`B_POST];
    tm.split = word && !cfg[`B_BW];
    tm.burst = !write && !fast_read_enable && cfg[`B_RBE] && tm.split;
    tm.bwait = tm.burst && cfg[`B_WBR];
    case (zone)
      Z_FLASH: begin
        if (!write) begin
          tm.acc = fast_read_enable ? `FAST_CYC : `NORM_CYC + wt + `FL_RD_EXTRA;
        end else if (fast_read_enable) begin
          tm.acc  = `NORM_CYC + `FL_FAST_WR;
          tm.hold = 2'h0;
        end else begin
          tm.acc = `NORM_CYC + wt + (early_write_select ? `FL_EARLY_EXTRA : `FL_LATE_EXTRA);
        end
      end
      Z_IO, Z_EXT1, Z_EXT2: begin
        if (!write) begin
          tm.acc = fast_read_enable ? `FAST_CYC : `NORM_CYC + wt;
        end else begin
          tm.acc = (early_write_select ? `EARLY_CYC : `NORM_CYC) + wt;
        end
      end
      Z_PERIPH: begin
        // Fixed timing regardless of any configuration word
        tm.acc   = `NORM_CYC + `PER_WAIT;
        tm.hold  = 2'h0;
        tm.pre   = 1'b1;
        tm.post  = 1'b0;
        tm.split = 1'b0;
        tm.burst = 1'b0;
        tm.bwait = 1'b0;
      end
      default: begin
        // RAM and unmapped space finish in one cycle
        tm.acc   = `FAST_CYC;
        tm.hold  = 2'h0;
        tm.pre   = 1'b0;
        tm.post  = 1'b0;
        tm.split = 1'b0;
        tm.burst = 1'b0;
        tm.bwait = 1'b0;
      end
    endcase
  end

endmodule

// >>> static_zone_bus_timing.sv
// Bus interface timing: zone configuration registers and access sequencer
//
// Overview of operation
// - Wait field adds zero to seven cycles
// - Hold field adds zero to three cycles
// - Fast read disregards wait and hold
// - Burst for word reads, not fast read
// - Burst wait bit adds one cycle
// - Width bit zero means eight-bit zone
// - Fast read one cycle, normal two plus
// - Post idle before different next zone
// - Preliminary idle before different new zone
// - Off-chip zone configs reset to 069Fh
// - Zone configs drive their own selects
// - Flash timing for program and data ranges
// - Flash fast read in one cycle
// - Flash normal read waits field plus one
// - Flash write in fast mode: one wait
// - Flash write waits plus one or two
// - RAM always single cycle
// - Peripherals: one wait, one preliminary idle
// - I/O zone uses its own config
// - Early write bit, reset selects early
//
// Flash fast read is only legal up to a 24 MHz core clock; nothing here
// checks the clock, so software must not set it at full speed.
`timescale 1ns/1ps
`include "bus_timing_defs.svh"
module static_zone_bus_timing #(
  parameter logic [23:0] EXT1_BASE = 24'h40_0000,
  parameter logic [23:0] EXT1_LAST = 24'h7F_FFFF,
  parameter logic [23:0] EXT2_BASE = 24'h80_0000,
  parameter logic [23:0] EXT2_LAST = 24'hBF_FFFF
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    req_valid,
  input  wire bus_timing_pkg::core_req_t req,
  input  wire logic [15:0]             mem_rdata,
  output logic                         req_ready,
  output logic                         ack,
  output logic [15:0]                  rdata,
  output logic [23:0]                  mem_addr,
  output bus_timing_pkg::ext_ctl_t     ext
);
  import bus_timing_pkg::*;

  // ********************************************************
  // Parameter checks
  // ********************************************************
  if (EXT1_LAST < EXT1_BASE || EXT2_LAST < EXT2_BASE) begin : g_bad_range
    $error("external zone range ends below its base");
  end

  state_t      s;
  state_t      next_s;
  zone_t       dz;
  timing_t     dtm;
  logic [15:0] dcfg;
  logic        accept;
  logic        diff;
  logic [1:0]  gap;
  logic        finish;
  logic        active;

  // ********************************************************
  // Address decode
  // ********************************************************
  // The I/O zone sits inside the peripheral range, so it is tested first
  function automatic zone_t decode(input logic [23:0] a);
    zone_t z;
    z = Z_NONE;
    if ((a >= `FL_PRG_LO && a <= `FL_PRG_HI) ||
        (a >= `FL_DAT_LO && a <= `FL_DAT_HI)) begin
      z = Z_FLASH;
    end else if ((a >= `RAM0_LO && a <= `RAM0_HI) ||
                 (a >= `RAM1_LO && a <= `RAM1_HI)) begin
      z = Z_RAM;
    end else if (a >= `IO_LO && a <= `IO_HI) begin
      z = Z_IO;
    end else if ((a >= `PER0_LO && a <= `PER0_HI) ||
                 (a >= `PER1_LO && a <= `PER1_HI)) begin
      z = Z_PERIPH;
    end else if (a >= EXT1_BASE && a <= EXT1_LAST) begin
      z = Z_EXT1;
    end else if (a >= EXT2_BASE && a <= EXT2_LAST) begin
      z = Z_EXT2;
    end
    return z;
  endfunction

  assign dz = decode(req.addr);

  // Pick the configuration word that governs the decoded zone
  always_comb begin
    case (dz)
      Z_FLASH: dcfg = s.cfg_fl;
      Z_IO:    dcfg = s.cfg_io;
      Z_EXT1:  dcfg = s.cfg_z1;
      Z_EXT2:  dcfg = s.cfg_z2;
      default: dcfg = 16'h0000;
    endcase
  end

  zone_timing_calc u_calc (
    .zone  (dz),
    .cfg   (dcfg),
    .write (req.write),
    .word  (req.word),
    .early_write_select   (s.early_write_select),
    .tm    (dtm)
  );

  // ********************************************************
  // Access sequencer
  // ********************************************************
  // Idle cycles only appear when the zone changes; both may stack
  assign accept = req_valid && s.ready;
  assign diff   = (dz != s.last);
  assign gap    = {1'b0, diff && s.last_post} + {1'b0, diff && dtm.pre};

  always_comb begin
    next_s         = s;
    next_s.ack     = 1'b0;
    next_s.run_len = s.run_len + 6'h01;
    finish         = 1'b0;
    case (s.ph)
      PH_IDLE: begin
        if (accept) begin
          next_s.req     = req;
          next_s.zone    = dz;
          next_s.tm      = dtm;
          next_s.half    = 1'b0;
          next_s.run_len = 6'h01;
          next_s.nogap   = (gap == 2'h0);
          if (gap != 2'h0) begin
            next_s.ph  = PH_GAP;
            next_s.cnt = {2'h0, gap} - 4'h1;
          end else begin
            next_s.ph  = PH_ACC;
            next_s.cnt = dtm.acc - 4'h1;
          end
        end
      end
      PH_GAP: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else begin
          next_s.ph  = PH_ACC;
          next_s.cnt = s.tm.acc - 4'h1;
        end
      end
      PH_ACC: begin
        // Wait cycles extend the address phase before any hold
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else if (s.tm.hold != 2'h0) begin
          next_s.ph  = PH_HOLD;
          next_s.cnt = {2'h0, s.tm.hold} - 4'h1;
        end else begin
          finish = 1'b1;
        end
      end
      PH_HOLD: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else begin
          finish = 1'b1;
        end
      end
      default: begin
        next_s.ph = PH_IDLE;
      end
    endcase

    // End of one bus cycle: second byte of a split word, or completion
    if (finish && s.tm.split && !s.half) begin
      next_s.half       = 1'b1;
      next_s.rdata[7:0] = mem_rdata[7:0];
      next_s.ph         = PH_ACC;
      if (s.tm.burst) begin
        next_s.cnt = {3'h0, s.tm.bwait};
      end else begin
        next_s.cnt = s.tm.acc - 4'h1;
      end
    end else if (finish) begin
      next_s.ph        = PH_IDLE;
      next_s.ack       = 1'b1;
      next_s.last      = s.zone;
      next_s.last_post = s.tm.post;
      if (s.tm.split) begin
        next_s.rdata[15:8] = mem_rdata[7:0];
      end else begin
        next_s.rdata = mem_rdata;
      end
      // Register reads and writes land at the end of their bus cycle
      case (s.req.addr)
        `A_BUS_UNIT_CFG: begin
          if (s.req.write) begin
            next_s.early_write_select = s.req.wdata[`B_EWR];
          end
          next_s.rdata = {13'h0000, `BUS_UNIT_CFG_FIXED, s.early_write_select};
        end
        `A_IO_ZONE_TIMING_CFG: begin
          if (s.req.write) begin
            next_s.cfg_io = s.req.wdata & `CFG_RW_MASK;
          end
          next_s.rdata = s.cfg_io;
        end
        `A_FLCFG: begin
          if (s.req.write) begin
            next_s.cfg_fl = s.req.wdata & `CFG_RW_MASK;
          end
          next_s.rdata = s.cfg_fl;
        end
        `A_Z1CFG: begin
          if (s.req.write) begin
            next_s.cfg_z1 = s.req.wdata & `CFG_RW_MASK;
          end
          next_s.rdata = s.cfg_z1;
        end
        `A_Z2CFG: begin
          if (s.req.write) begin
            next_s.cfg_z2 = s.req.wdata & `CFG_RW_MASK;
          end
          next_s.rdata = s.cfg_z2;
        end
        default: begin
        end
      endcase
    end

    // Outputs registered from the next state
    active          = (next_s.ph == PH_ACC) || (next_s.ph == PH_HOLD);
    next_s.ready    = (next_s.ph == PH_IDLE);
    next_s.mem_addr = {next_s.req.addr[23:1], next_s.req.addr[0] | next_s.half};
    next_s.ext.zone1_select_out = active && (next_s.zone == Z_EXT1);
    next_s.ext.zone2_select_out = active && (next_s.zone == Z_EXT2);
    next_s.ext.rd   = (next_s.ext.zone1_select_out || next_s.ext.zone2_select_out) && !next_s.req.write;
    next_s.ext.wr   = (next_s.ext.zone1_select_out || next_s.ext.zone2_select_out) && next_s.req.write &&
                      (next_s.ph == PH_ACC);
  end

  // ********************************************************
  // State register
  // ********************************************************
  // Reset state: all four zone words at their documented value, early write
  always_ff @(posedge clk) begin
    if (rst) begin
      s           <= '0;
      s.ph        <= PH_IDLE;
      s.zone      <= Z_NONE;
      s.last      <= Z_NONE;
      s.cfg_io    <= `RST_ZONE_CFG;
      s.cfg_fl    <= `RST_ZONE_CFG;
      s.cfg_z1    <= `RST_ZONE_CFG;
      s.cfg_z2    <= `RST_ZONE_CFG;
      s.early_write_select       <= `RST_EWR;
      s.ready     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign req_ready = s.ready;
  assign ack       = s.ack;
  assign rdata     = s.rdata;
  assign mem_addr  = s.mem_addr;
  assign ext       = s.ext;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  cfg_reset_a: assert property ($fell(rst) |-> s.cfg_z1 == `RST_ZONE_CFG &&
      s.cfg_z2 == `RST_ZONE_CFG && s.early_write_select)
    else $error("zone words or early write wrong after reset");

  ram_single_a: assert property (accept && dz == Z_RAM && !s.last_post |->
      ##1 !ack ##1 ack)
    else $error("RAM access not single cycle");

  periph_time_a: assert property (accept && dz == Z_PERIPH && s.last == Z_PERIPH |->
      ##1 !ack [*3] ##1 ack)
    else $error("peripheral access timing wrong");

  flash_rd_a: assert property (ack && s.last == Z_FLASH && !s.req.write && s.nogap &&
      !s.cfg_fl[`B_FRE] |-> s.run_len == 6'(`NORM_CYC + `FL_RD_EXTRA +
      s.cfg_fl[`F_WAIT] + s.cfg_fl[`F_HOLD]) + `ACK_LAG)
    else $error("flash normal read length wrong");

  flash_fast_a: assert property (ack && s.last == Z_FLASH && s.nogap &&
      s.cfg_fl[`B_FRE] |-> s.run_len == (s.req.write ?
      6'(`NORM_CYC + `FL_FAST_WR) : 6'(`FAST_CYC)) + `ACK_LAG)
    else $error("flash fast mode length wrong");

  flash_wr_a: assert property (ack && s.last == Z_FLASH && s.req.write && s.nogap &&
      !s.cfg_fl[`B_FRE] |-> s.run_len == 6'(`NORM_CYC + s.cfg_fl[`F_WAIT] +
      (s.early_write_select ? `FL_EARLY_EXTRA : `FL_LATE_EXTRA) + s.cfg_fl[`F_HOLD]) + `ACK_LAG)
    else $error("flash write length wrong");

  ext_rd_a: assert property (ack && s.last == Z_EXT1 && !s.req.write && s.nogap &&
      !s.cfg_z1[`B_FRE] && !s.tm.split |-> s.run_len == 6'(`NORM_CYC +
      s.cfg_z1[`F_WAIT] + s.cfg_z1[`F_HOLD]) + `ACK_LAG)
    else $error("zone one normal read length wrong");

  ext_fast_a: assert property (ack && s.last == Z_EXT2 && !s.req.write && s.nogap &&
      s.cfg_z2[`B_FRE] && !s.tm.split |-> s.run_len == 6'(`FAST_CYC) + `ACK_LAG)
    else $error("zone two fast read length wrong");

  burst_len_a: assert property (ack && s.last == Z_EXT1 && s.tm.burst && s.nogap |->
      s.run_len == 6'(`NORM_CYC + s.cfg_z1[`F_WAIT] + s.cfg_z1[`F_HOLD] +
      `FAST_CYC + s.cfg_z1[`B_WBR] + s.cfg_z1[`F_HOLD]) + `ACK_LAG)
    else $error("burst read length wrong");

  idle_gap_a: assert property (accept && dz != s.last && (s.last_post || dtm.pre) |=>
      s.ph == PH_GAP && !ext.zone1_select_out && !ext.zone2_select_out)
    else $error("idle cycle missing on zone change");

  sel_zone_a: assert property (ext.zone1_select_out |-> !ext.zone2_select_out && s.zone == Z_EXT1)
    else $error("zone one select without zone one access");

  ram_cover_c: cover property (accept && dz == Z_RAM ##2 ack);
  burst_cover_c: cover property (ack && s.tm.burst);
  gap_cover_c: cover property (s.ph == PH_GAP ##1 s.ph == PH_ACC);
  fast_cover_c: cover property (ack && s.last == Z_EXT2 && s.cfg_z2[`B_FRE]);

endmodule

// >>> mem_partner_model.sv
// Far-side model: off-chip static memories on both selects plus on-chip arrays
`timescale 1ns/1ps
module mem_partner_model (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [23:0]              mem_addr,
  input  wire bus_timing_pkg::ext_ctl_t ext,
  output logic [15:0]                   mem_rdata
);
  import bus_timing_pkg::*;

  logic [15:0] junk;
  logic        off_chip;

  // ************************************************
  // Released bus
  // ************************************************
  // A released bus flips every cycle, so a late or early sample never matches
  always_ff @(posedge clk) begin
    if (rst) begin
      junk <= 16'h5a5a;
    end else begin
      junk <= ~junk;
    end
  end

  // ************************************************
  // Read data
  // ************************************************
  // Off-chip parts answer only while read is driven; on-chip arrays always answer
  assign off_chip  = (mem_addr[23:22] == 2'b01) || (mem_addr[23:22] == 2'b10);
  assign mem_rdata = (ext.rd || !off_chip) ? {~mem_addr[7:0], mem_addr[7:0]} : junk;
endmodule

// >>> static_zone_bus_timing_test.sv
// Self-checking bench for the zone bus timing block
`timescale 1ns/1ps
`include "bus_timing_defs.svh"
module static_zone_bus_timing_test;
  import bus_timing_pkg::*;

  logic        clk;
  logic        rst;
  logic        req_valid;
  core_req_t   req;
  logic [15:0] mem_rdata;
  logic        req_ready;
  logic        ack;
  logic [15:0] rdata;
  logic [23:0] mem_addr;
  ext_ctl_t    ext;
  int          fail_count;
  int          tests_run;
  logic [15:0] rd;
  logic        saw1;
  logic        saw2;
  logic        sawwr;
  logic        sawodd;

  static_zone_bus_timing static_zone_bus_timing_i (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .mem_rdata(mem_rdata),
    .req_ready(req_ready), .ack(ack), .rdata(rdata), .mem_addr(mem_addr), .ext(ext));
  mem_partner_model mem_partner_model_i (
    .clk(clk), .rst(rst), .mem_addr(mem_addr), .ext(ext), .mem_rdata(mem_rdata));

  // ************************************************
  // Clock and shared tasks
  // ************************************************
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [15:0] pat(input logic [23:0] a);
    return {~a[7:0], a[7:0]};
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One core access; counts cycles from the taking edge, itself included, to the ack cycle
  task automatic acc(input logic [23:0] a, input logic w, input logic wd,
                     input logic [15:0] d, input int e);
    int n;
    int k;
    n = 1;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{addr: a, write: w, word: wd, wdata: d};
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (req_ready === 1'b1) break;
    end
    req_valid <= 1'b0;
    // A request that is never taken ends the run as a mismatch
    if (k == 50) begin
      fail_count++;
      $display("[ERR] req_ready expected 1 seen 0");
      complete_run();
    end
    {saw1, saw2, sawwr, sawodd} = 4'h0;
    // Bounded wait so a lost ack ends the run instead of hanging it
    for (k = 0; k < 60 && k < 50; k++) begin
      @(posedge clk);
      n++;
      #1;
      saw1 |= ext.zone1_select_out;
      saw2 |= ext.zone2_select_out;
      sawwr |= ext.wr;
      sawodd |= mem_addr[0];
      if (ack === 1'b1) break;
    end
    if (k == 50) begin
      fail_count++;
      $display("[ERR] ack expected 1 seen 0");
      complete_run();
    end
    rd = rdata;
    if (e != 0) check("cycles", 16'(n), 16'(e));
  endtask

  task automatic wreg(input logic [23:0] a, input logic [15:0] v);
    acc(a, 1'b1, 1'b1, v, 0);
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  // Reset values, bus config, masked reserved bits
  task automatic s_regs();
    acc(`A_Z1CFG, 1'b0, 1'b1, 16'h0000, 5);
    check("zone1_cfg", rd, 16'h069f);
    acc(`A_Z2CFG, 1'b0, 1'b1, 16'h0000, 4);
    check("zone2_cfg", rd, 16'h069f);
    acc(`A_BUS_UNIT_CFG, 1'b0, 1'b1, 16'h0000, 4);
    check("bus_cfg", rd, 16'h0007);
    wreg(`A_BUS_UNIT_CFG, 16'h0006);
    wreg(`A_Z2CFG, 16'hffff);
    acc(`A_Z2CFG, 1'b0, 1'b1, 16'h0000, 0);
    check("zone2_cfg", rd, 16'h0eff);
  endtask

  // Every wait value on zone 1, every hold value on zone 2
  task automatic s_wait_hold();
    for (int w = 0; w < 8; w++) begin
      wreg(`A_Z1CFG, 16'h0080 | 16'(w));
      acc(24'h40_0010, 1'b0, 1'b1, 16'h0000, 3 + w);
      check("zone1_select_out", {15'h0, saw1}, 16'h0001);
      check("zone2_select_out", {15'h0, saw2}, 16'h0000);
      check("rdata", rd, pat(24'h40_0010));
    end
    for (int h = 0; h < 4; h++) begin
      wreg(`A_Z2CFG, 16'h0080 | 16'(h << 3));
      acc(24'h80_0020, 1'b0, 1'b1, 16'h0000, 3 + h);
      check("zone2_select_out", {15'h0, saw2}, 16'h0001);
    end
  endtask

  // Fast read drops wait and hold; bursts on byte-wide zone
  task automatic s_fast_burst();
    wreg(`A_Z1CFG, 16'h089f);
    acc(24'h40_0000, 1'b0, 1'b1, 16'h0000, 2);
    check("rdata", rd, pat(24'h40_0000));
    acc(24'h40_0002, 1'b1, 1'b1, 16'h1234, 3);
    check("wr", {15'h0, sawwr}, 16'h0001);
    wreg(`A_Z2CFG, 16'h089f);
    acc(24'h80_0000, 1'b0, 1'b1, 16'h0000, 2);
    check("rdata", rd, pat(24'h80_0000));
    wreg(`A_Z1CFG, 16'h0020);
    acc(24'h40_0004, 1'b0, 1'b1, 16'h0000, 4);
    check("odd_byte", {15'h0, sawodd}, 16'h0001);
    check("split_rdata", rd, 16'h0504);
    wreg(`A_Z1CFG, 16'h0060);
    acc(24'h40_0004, 1'b0, 1'b1, 16'h0000, 5);
    wreg(`A_Z1CFG, 16'h0000);
    acc(24'h40_0004, 1'b0, 1'b1, 16'h0000, 5);
    acc(24'h40_0004, 1'b0, 1'b0, 16'h0000, 3);
    wreg(`A_Z1CFG, 16'h0820);
    acc(24'h40_0004, 1'b0, 1'b1, 16'h0000, 3);
    wreg(`A_Z1CFG, 16'h00a0);
    acc(24'h40_0004, 1'b0, 1'b1, 16'h0000, 3);
  endtask

  // Idle cycles only when the zone changes
  task automatic s_idle();
    wreg(`A_Z1CFG, 16'h0480);
    wreg(`A_Z2CFG, 16'h0280);
    acc(24'h80_0000, 1'b0, 1'b1, 16'h0000, 3);
    acc(24'h40_0000, 1'b0, 1'b1, 16'h0000, 5);
    acc(24'h40_0000, 1'b0, 1'b1, 16'h0000, 3);
    acc(24'h80_0000, 1'b0, 1'b1, 16'h0000, 3);
    acc(24'h0e_8000, 1'b0, 1'b1, 16'h0000, 3);
    acc(24'h40_0000, 1'b0, 1'b1, 16'h0000, 4);
  endtask

  // Flash reads and writes in all modes
  task automatic s_flash();
    wreg(`A_FLCFG, 16'h008a);
    acc(24'h00_0100, 1'b0, 1'b1, 16'h0000, 7);
    acc(24'h0e_0010, 1'b0, 1'b1, 16'h0000, 7);
    acc(24'h00_0100, 1'b1, 1'b1, 16'h5555, 7);
    wreg(`A_BUS_UNIT_CFG, 16'h0007);
    acc(24'h00_0100, 1'b1, 1'b1, 16'h5555, 8);
    wreg(`A_FLCFG, 16'h088a);
    acc(24'h00_0100, 1'b0, 1'b1, 16'h0000, 2);
    acc(24'h00_0100, 1'b1, 1'b1, 16'haaaa, 4);
    wreg(`A_BUS_UNIT_CFG, 16'h0006);
  endtask

  // RAM, peripheral and I/O zone timing
  task automatic s_onchip();
    acc(24'h0e_8000, 1'b0, 1'b1, 16'h0000, 2);
    check("rdata", rd, pat(24'h0e_8000));
    acc(24'h0e_ebfe, 1'b1, 1'b1, 16'h0f0f, 2);
    acc(24'h0e_c000, 1'b0, 1'b1, 16'h0000, 2);
    acc(24'h0e_f000, 1'b0, 1'b1, 16'h0000, 5);
    acc(24'hff_0000, 1'b0, 1'b1, 16'h0000, 4);
    wreg(`A_IO_ZONE_TIMING_CFG, 16'h0085);
    acc(24'hff_fb00, 1'b0, 1'b1, 16'h0000, 8);
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    fail_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    s_regs();
    s_wait_hold();
    s_fast_burst();
    s_idle();
    s_flash();
    s_onchip();
    complete_run();
  end
endmodule
